// File: dca_pkg.sv
// constants, field layout and encodings for the command/address front end
package dca_pkg;

  // pin bundle layout inside the synchroniser word
  localparam int PIN_W = 34;
  localparam int P_CKT = 0;
  localparam int P_CKC = 1;
  localparam int P_CS  = 2;
  localparam int P_CKE = 4;
  localparam int P_ODT = 6;
  localparam int P_ACT = 8;
  localparam int P_RAS = 9;
  localparam int P_CAS = 10;
  localparam int P_WE  = 11;
  localparam int P_BG  = 12;
  localparam int P_BA  = 14;
  localparam int P_A   = 16;
  localparam int P_CID = 30;
  localparam int P_PAR = 33;

  // widths
  localparam int A_W   = 14;
  localparam int ROW_W = 17;
  localparam int A10   = 10;

  // reset values
  localparam logic [15:0]      RST_OPEN = 16'h0000;
  localparam logic [ROW_W-1:0] RST_ROW  = 17'h00000;
  localparam logic [PIN_W-1:0] RST_PINS = 34'h000000000;

  // chip id masks per stack height
  localparam logic [2:0] CID_M_NONE = 3'h0;
  localparam logic [2:0] CID_M_2H   = 3'h1;
  localparam logic [2:0] CID_M_4H   = 3'h3;
  localparam logic [2:0] CID_M_8H   = 3'h7;

  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_RSV = 4'h3,
    CMD_WR  = 4'h4,
    CMD_RD  = 4'h5,
    CMD_ZQ  = 4'h6,
    CMD_NOP = 4'h7,
    CMD_ACT = 4'h8
  } dca_cmd_type;

  typedef enum logic [3:0] {
    PWR_ON  = 4'h1,
    PWR_APD = 4'h2,
    PWR_PPD = 4'h4,
    PWR_SR  = 4'h8
  } dca_pwr_type;

  typedef enum logic [1:0] {
    ORG_X4  = 2'h0,
    ORG_X8  = 2'h1,
    ORG_X16 = 2'h2
  } dca_org_type;

  typedef enum logic [2:0] {
    STK_1H  = 3'h0,
    STK_2H  = 3'h1,
    STK_4H  = 3'h2,
    STK_8H  = 3'h3,
    STK_DDP = 3'h4
  } dca_stack_type;

endpackage

// File: dca_pin_if.sv
// carrier between the core and its pin synchroniser
interface dca_pin_if
  import dca_pkg::*;
();
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] clean;

  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface

// File: dca_pin_sync.sv
// three-stage pin synchroniser with agreement filter
module dca_pin_sync
  import dca_pkg::*;
#(
  parameter int W = PIN_W
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // pins in, filtered levels out
  dca_pin_if.sync   pins
);

  logic [W-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
  logic [W-1:0] nxt_clean;

  // a bit moves only once stages two and three agree, so a metastable
  // first stage never reaches the consumer
  always_comb begin
    nxt_clean = clean_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_clean[i] = s3_ff[i];
      end
    end
    if (!resetn) begin
      nxt_clean = RST_PINS[W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    s1_ff    <= pins.raw;
    s2_ff    <= s1_ff;
    s3_ff    <= s2_ff;
    clean_ff <= nxt_clean;
  end

  assign pins.clean = clean_ff;

endmodule // dca_pin_sync

// File: dca_cmd_front.sv
// What this block does
// - act low with chip select means activate
// - on activate, ras/cas/we are A16/A15/A14
// - bank address picks bank within group
// - on mode set, bank bits pick register
// - bank group bits pick target group
// - x16 decodes only low bank group bit
// - stacked x4/x8 dies selected by chip id bits, x16 ignores them
// - dual-die package uses second cs/cke/odt
// - inputs sampled at true clock rising crossing
// - cke high enables clocks, buffers, drivers
// - cke low enters power-down or self refresh
// - self refresh exit on cke without clock
// - power-down keeps only ck, odt, reset, cke
// - self refresh keeps only cke and reset
// - chip select high ignores the command
// - chip select is rank selector, part of command
// - termination only on data, strobe, mask lines
// - termination disabled ignores odt input
// - parity over act, cmd, bg, ba, address
// - act high makes ras/cas/we command bits
// - async active-low reset, blocked while armed
module dca_cmd_front
  import dca_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          resetn,
  // memory reset pin and backup arming
  input  wire logic          dram_reset_n,
  input  wire logic          backup_armed,
  // command clock pins
  input  wire logic          ck_t,
  input  wire logic          ck_c,
  // control pins
  input  wire logic [1:0]    cs_n,
  input  wire logic [1:0]    cke,
  input  wire logic [1:0]    odt,
  // command and address pins
  input  wire logic          act_n,
  input  wire logic          ras_n,
  input  wire logic          cas_n,
  input  wire logic          we_n,
  input  wire logic [1:0]    bg,
  input  wire logic [1:0]    ba,
  input  wire logic [A_W-1:0] addr,
  input  wire logic [2:0]    cid,
  input  wire logic          par_in,
  // static configuration
  input  wire dca_org_type   org,
  input  wire dca_stack_type stack,
  input  wire logic [2:0]    die_id,
  input  wire logic          ddp_die,
  input  wire logic          parity_en,
  input  wire logic          rtt_disabled,
  input  wire logic          tdqs_en,
  // decoded command
  output logic               cmd_valid,
  output dca_cmd_type        cmd_code,
  output logic [1:0]         cmd_bg,
  output logic [1:0]         cmd_ba,
  output logic [ROW_W-1:0]   cmd_addr,
  output logic [2:0]         mr_sel,
  output logic               parity_err,
  // power and buffer state
  output dca_pwr_type        pwr_state,
  output logic               clk_en,
  output logic               buf_cmd_en,
  output logic               buf_odt_en,
  output logic               buf_ck_en,
  output logic [15:0]        open_banks,
  // termination
  output logic               odt_apply,
  output logic               odt_mask_lines
);

  dca_pin_if pins ();

  assign pins.raw = {par_in, cid, addr, ba, bg, we_n, cas_n, ras_n, act_n, odt, cke, cs_n,
                     ck_c, ck_t};

  dca_pin_sync #(.W(PIN_W)) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pins   (pins)
  );

  // the pin reset acts without the clock but cannot fire while armed
  logic core_rst_n;
  assign core_rst_n = dram_reset_n | backup_armed;

  // filtered pin fields
  logic [PIN_W-1:0] c;
  assign c = pins.clean;

  logic             s_ckt, s_ckc, s_act, s_ras, s_cas, s_we, s_par;
  logic [1:0]       s_cs, s_cke, s_odt, s_bg, s_ba;
  logic [A_W-1:0]   s_a;
  logic [2:0]       s_cid;
  assign s_ckt = c[P_CKT];
  assign s_ckc = c[P_CKC];
  assign s_cs  = c[P_CS +: 2];
  assign s_cke = c[P_CKE +: 2];
  assign s_odt = c[P_ODT +: 2];
  assign s_act = c[P_ACT];
  assign s_ras = c[P_RAS];
  assign s_cas = c[P_CAS];
  assign s_we  = c[P_WE];
  assign s_bg  = c[P_BG +: 2];
  assign s_ba  = c[P_BA +: 2];
  assign s_a   = c[P_A +: A_W];
  assign s_cid = c[P_CID +: 3];
  assign s_par = c[P_PAR];

  // registered state
  logic             cross_ff, cmd_valid_ff, parity_err_ff;
  dca_cmd_type      cmd_code_ff;
  logic [1:0]       cmd_bg_ff, cmd_ba_ff;
  logic [ROW_W-1:0] cmd_addr_ff;
  logic [2:0]       mr_sel_ff;
  dca_pwr_type      pwr_ff;
  logic             clk_en_ff, buf_cmd_ff, buf_odt_ff, buf_ck_ff;
  logic [15:0]      open_ff;
  logic             odt_apply_ff, odt_mask_ff;

  logic             nxt_cross, nxt_cmd_valid, nxt_parity_err;
  dca_cmd_type      nxt_cmd_code;
  logic [1:0]       nxt_cmd_bg, nxt_cmd_ba;
  logic [ROW_W-1:0] nxt_cmd_addr;
  logic [2:0]       nxt_mr_sel;
  dca_pwr_type      nxt_pwr;
  logic             nxt_clk_en, nxt_buf_cmd, nxt_buf_odt, nxt_buf_ck;
  logic [15:0]      nxt_open;
  logic             nxt_odt_apply, nxt_odt_mask;

  // sampling edge: true high and complement low, first cycle of it
  logic crossing, ck_rise;
  assign crossing = s_ckt & ~s_ckc;
  assign ck_rise  = crossing & ~cross_ff;

  // die selection: second die of a dual-die package has its own controls
  logic sel_idx, cs_sel, cke_sel, odt_sel, id_ok, selected;
  logic [2:0] cid_mask;
  assign sel_idx = (stack == STK_DDP) ? ddp_die : 1'b0;
  assign cs_sel  = ~s_cs[sel_idx];
  assign cke_sel = s_cke[sel_idx];
  assign odt_sel = s_odt[sel_idx];

  always_comb begin
    case (stack)
      STK_2H:  cid_mask = CID_M_2H;
      STK_4H:  cid_mask = CID_M_4H;
      STK_8H:  cid_mask = CID_M_8H;
      default: cid_mask = CID_M_NONE;
    endcase
    if (org == ORG_X16) begin
      cid_mask = CID_M_NONE;
    end
  end

  assign id_ok    = ((s_cid ^ die_id) & cid_mask) == CID_M_NONE;
  assign selected = cs_sel & id_ok;

  // command decode
  dca_cmd_type dec_code;
  logic [1:0]  bg_eff;
  logic [3:0]  bank_idx;
  assign dec_code = s_act ? dca_cmd_type'({1'b0, s_ras, s_cas, s_we}) : CMD_ACT;
  assign bg_eff   = (org == ORG_X16) ? {1'b0, s_bg[0]} : s_bg;
  assign bank_idx = {bg_eff, s_ba};

  // only a clock-running device takes commands
  logic take;
  assign take = ck_rise & selected & (pwr_ff == PWR_ON);

  // even parity across the covered pins plus the parity pin
  logic par_odd;
  assign par_odd = ^{s_act, s_ras, s_cas, s_we, s_bg, s_ba, s_a, s_par};

  always_comb begin
    nxt_cross      = crossing;
    nxt_cmd_valid  = 1'b0;
    nxt_cmd_code   = cmd_code_ff;
    nxt_cmd_bg     = cmd_bg_ff;
    nxt_cmd_ba     = cmd_ba_ff;
    nxt_cmd_addr   = cmd_addr_ff;
    nxt_mr_sel     = mr_sel_ff;
    nxt_parity_err = 1'b0;
    nxt_pwr        = pwr_ff;
    nxt_open       = open_ff;
    nxt_odt_apply  = odt_apply_ff;
    nxt_odt_mask   = odt_mask_ff;

    if (take && cke_sel) begin
      nxt_cmd_valid = 1'b1;
      nxt_cmd_code  = dec_code;
      nxt_cmd_bg    = bg_eff;
      nxt_cmd_ba    = s_ba;
      nxt_mr_sel    = {s_bg[0], s_ba};
      if (dec_code == CMD_ACT) begin
        nxt_cmd_addr = {s_ras, s_cas, s_we, s_a};
      end else begin
        nxt_cmd_addr = {3'h0, s_a};
      end
      case (dec_code)
        CMD_ACT: nxt_open[bank_idx] = 1'b1;
        CMD_PRE: begin
          if (s_a[A10]) begin
            nxt_open = RST_OPEN;
          end else begin
            nxt_open[bank_idx] = 1'b0;
          end
        end
        CMD_RD, CMD_WR: begin
          if (s_a[A10]) begin
            nxt_open[bank_idx] = 1'b0;
          end
        end
        default: nxt_open = open_ff;
      endcase
    end

    // parity is checked whenever chip select picks this die and inputs listen
    if (ck_rise && selected && parity_en && pwr_ff == PWR_ON && par_odd) begin
      nxt_parity_err = 1'b1;
    end

    case (pwr_ff)
      PWR_ON: begin
        if (ck_rise && !cke_sel) begin
          if (selected && dec_code == CMD_REF) begin
            nxt_pwr = PWR_SR;
          end else if (open_ff == RST_OPEN) begin
            nxt_pwr = PWR_PPD;
          end else begin
            nxt_pwr = PWR_APD;
          end
        end
      end
      PWR_APD, PWR_PPD: begin
        if (ck_rise && cke_sel) begin
          nxt_pwr = PWR_ON;
        end
      end
      PWR_SR: begin
        // no clock edge needed: the clock may be stopped in self refresh
        if (cke_sel) begin
          nxt_pwr = PWR_ON;
        end
      end
      default: nxt_pwr = PWR_ON;
    endcase

    // termination keeps listening in power-down, not in self refresh
    if (ck_rise && pwr_ff != PWR_SR) begin
      nxt_odt_apply = odt_sel & ~rtt_disabled;
      nxt_odt_mask  = odt_sel & ~rtt_disabled & ((org == ORG_X16) | tdqs_en);
    end else if (pwr_ff == PWR_SR || rtt_disabled) begin
      nxt_odt_apply = 1'b0;
      nxt_odt_mask  = 1'b0;
    end

    if (!resetn) begin
      nxt_cross      = 1'b0;
      nxt_cmd_valid  = 1'b0;
      nxt_cmd_code   = CMD_NOP;
      nxt_cmd_bg     = 2'h0;
      nxt_cmd_ba     = 2'h0;
      nxt_cmd_addr   = RST_ROW;
      nxt_mr_sel     = 3'h0;
      nxt_parity_err = 1'b0;
      nxt_pwr        = PWR_ON;
      nxt_open       = RST_OPEN;
      nxt_odt_apply  = 1'b0;
      nxt_odt_mask   = 1'b0;
    end
  end

  // buffer and clock enables follow the next power state
  always_comb begin
    nxt_clk_en  = (nxt_pwr == PWR_ON);
    nxt_buf_cmd = (nxt_pwr == PWR_ON);
    nxt_buf_odt = (nxt_pwr != PWR_SR);
    nxt_buf_ck  = (nxt_pwr != PWR_SR);
  end

  always_ff @(posedge mclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cross_ff      <= 1'b0;
      cmd_valid_ff  <= 1'b0;
      cmd_code_ff   <= CMD_NOP;
      cmd_bg_ff     <= 2'h0;
      cmd_ba_ff     <= 2'h0;
      cmd_addr_ff   <= RST_ROW;
      mr_sel_ff     <= 3'h0;
      parity_err_ff <= 1'b0;
      pwr_ff        <= PWR_ON;
      clk_en_ff     <= 1'b1;
      buf_cmd_ff    <= 1'b1;
      buf_odt_ff    <= 1'b1;
      buf_ck_ff     <= 1'b1;
      open_ff       <= RST_OPEN;
      odt_apply_ff  <= 1'b0;
      odt_mask_ff   <= 1'b0;
    end else begin
      cross_ff      <= nxt_cross;
      cmd_valid_ff  <= nxt_cmd_valid;
      cmd_code_ff   <= nxt_cmd_code;
      cmd_bg_ff     <= nxt_cmd_bg;
      cmd_ba_ff     <= nxt_cmd_ba;
      cmd_addr_ff   <= nxt_cmd_addr;
      mr_sel_ff     <= nxt_mr_sel;
      parity_err_ff <= nxt_parity_err;
      pwr_ff        <= nxt_pwr;
      clk_en_ff     <= nxt_clk_en;
      buf_cmd_ff    <= nxt_buf_cmd;
      buf_odt_ff    <= nxt_buf_odt;
      buf_ck_ff     <= nxt_buf_ck;
      open_ff       <= nxt_open;
      odt_apply_ff  <= nxt_odt_apply;
      odt_mask_ff   <= nxt_odt_mask;
    end
  end

  assign cmd_valid      = cmd_valid_ff;
  assign cmd_code       = cmd_code_ff;
  assign cmd_bg         = cmd_bg_ff;
  assign cmd_ba         = cmd_ba_ff;
  assign cmd_addr       = cmd_addr_ff;
  assign mr_sel         = mr_sel_ff;
  assign parity_err     = parity_err_ff;
  assign pwr_state      = pwr_ff;
  assign clk_en         = clk_en_ff;
  assign buf_cmd_en     = buf_cmd_ff;
  assign buf_odt_en     = buf_odt_ff;
  assign buf_ck_en      = buf_ck_ff;
  assign open_banks     = open_ff;
  assign odt_apply      = odt_apply_ff;
  assign odt_mask_lines = odt_mask_ff;

endmodule // dca_cmd_front

// File: dca_cmd_front_props.sv
// concurrent checks on the command/address front end ports
module dca_cmd_front_props
  import dca_pkg::*;
(
  // clock and resets
  input wire logic             mclk,
  input wire logic             resetn,
  input wire logic             dram_reset_n,
  input wire logic             backup_armed,
  // configuration
  input wire dca_org_type      org,
  input wire logic             parity_en,
  input wire logic             rtt_disabled,
  input wire logic             tdqs_en,
  // decoded command
  input wire logic             cmd_valid,
  input wire dca_cmd_type      cmd_code,
  input wire logic [1:0]       cmd_bg,
  input wire logic [1:0]       cmd_ba,
  input wire logic [ROW_W-1:0] cmd_addr,
  input wire logic [2:0]       mr_sel,
  input wire logic             parity_err,
  // power, buffers, termination
  input wire dca_pwr_type      pwr_state,
  input wire logic             clk_en,
  input wire logic             buf_cmd_en,
  input wire logic             buf_odt_en,
  input wire logic             buf_ck_en,
  input wire logic [15:0]      open_banks,
  input wire logic             odt_apply,
  input wire logic             odt_mask_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  // the memory reset pin clears state too, unless backup arming blocks it
  default disable iff (!resetn || (!dram_reset_n && !backup_armed));

  a_valid_one_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe held longer than one cycle");
  a_nonact_upper_zero: assert property (
    cmd_valid && cmd_code != CMD_ACT |-> cmd_addr[16:14] == 3'h0)
    else $error("upper row bits set on a non-activate command");
  a_x16_group_bit: assert property (cmd_valid && org == ORG_X16 |-> !cmd_bg[1])
    else $error("high bank group bit decoded in x16");
  a_mode_reg_sel: assert property (
    cmd_valid && cmd_code == CMD_MRS |-> mr_sel == {cmd_bg[0], cmd_ba})
    else $error("mode register select does not follow bank bits");
  a_act_opens_bank: assert property (
    cmd_valid && cmd_code == CMD_ACT |-> open_banks[{cmd_bg, cmd_ba}])
    else $error("activated bank not marked open");
  a_off_no_cmd: assert property (pwr_state != PWR_ON |=> !cmd_valid)
    else $error("command accepted outside the on state");
  a_pd_buffers: assert property (
    pwr_state inside {PWR_APD, PWR_PPD} |->
      !clk_en && !buf_cmd_en && buf_odt_en && buf_ck_en)
    else $error("wrong buffer enables in power-down");
  a_sr_buffers: assert property (
    pwr_state == PWR_SR |-> !clk_en && !buf_cmd_en && !buf_odt_en && !buf_ck_en)
    else $error("wrong buffer enables in self refresh");
  a_pd_kind: assert property (
    $changed(pwr_state) && pwr_state inside {PWR_APD, PWR_PPD} |->
      (pwr_state == PWR_APD) == (open_banks != 16'h0000))
    else $error("power-down kind does not match open banks");
  a_odt_off: assert property (rtt_disabled || pwr_state == PWR_SR |=> !odt_apply)
    else $error("termination applied while disabled");
  a_mask_lines: assert property (
    odt_mask_lines |-> odt_apply && (org == ORG_X16 || tdqs_en))
    else $error("termination on mask lines without its condition");
  a_parity_pulse: assert property (parity_err |-> parity_en ##1 !parity_err)
    else $error("parity flag without enable or too long");
endmodule // dca_cmd_front_props

// File: dca_host_model.sv
// host controller model driving the command/address pins
module dca_host_model
  import dca_pkg::*;
(
  // clock
  input wire logic       mclk,
  // pins toward the device
  output logic           ck_t,
  output logic           ck_c,
  output logic [1:0]     cs_n,
  output logic [1:0]     cke,
  output logic [1:0]     odt,
  output logic           act_n,
  output logic           ras_n,
  output logic           cas_n,
  output logic           we_n,
  output logic [1:0]     bg,
  output logic [1:0]     ba,
  output logic [A_W-1:0] addr,
  output logic [2:0]     cid,
  output logic           par_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {ck_t, ck_c, cs_n, cke, odt} = 8'h7C;
    {act_n, ras_n, cas_n, we_n, bg, ba, addr, cid, par_in} = 26'h3FFFFFF;
  end

  // one frame: pins settle, one rising crossing, then release
  task automatic frame(input logic [1:0] cs, input logic [1:0] ke, input logic [1:0] od,
                       input logic [3:0] op, input logic [1:0] g, input logic [1:0] b,
                       input logic [A_W-1:0] a, input logic [2:0] c, input logic bad);
    @(posedge mclk);
    {cs_n, cke, odt, act_n, ras_n, cas_n, we_n, bg, ba, addr, cid} <= {cs, ke, od, op, g, b, a, c};
    par_in <= ^{op, g, b, a} ^ bad;
    repeat (5) @(posedge mclk);
    ck_t <= 1'b1;
    ck_c <= 1'b0;
    repeat (8) @(posedge mclk);
    ck_t <= 1'b0;
    ck_c <= 1'b1;
    // scrambled after release so a stale value is never mistaken for a fresh one
    cs_n <= 2'b11;
    addr <= ~a;
    repeat (6) @(posedge mclk);
  endtask

  // clock enable alone, command clock stands still
  task automatic set_cke(input logic [1:0] ke);
    @(posedge mclk);
    cke <= ke;
  endtask
endmodule // dca_host_model

// File: test_dca_cmd_front.sv
// self-checking bench for the command/address front end
module test_dca_cmd_front
  import dca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, resetn = 1'b0, dram_reset_n = 1'b1, backup_armed = 1'b0;
  logic ddp_die = 1'b0, parity_en = 1'b1, rtt_disabled = 1'b0, tdqs_en = 1'b0;
  logic [2:0]    die_id = 3'h0;
  dca_org_type   org = ORG_X4;
  dca_stack_type stack = STK_1H;
  logic ck_t, ck_c, act_n, ras_n, cas_n, we_n, par_in, cmd_valid, parity_err;
  logic clk_en, buf_cmd_en, buf_odt_en, buf_ck_en, odt_apply, odt_mask_lines;
  logic [1:0]       cs_n, cke, odt, bg, ba, cmd_bg, cmd_ba;
  logic [A_W-1:0]   addr;
  logic [2:0]       cid, mr_sel;
  logic [ROW_W-1:0] cmd_addr;
  logic [15:0]      open_banks;
  dca_cmd_type      cmd_code;
  dca_pwr_type      pwr_state;
  int err_total = 0, checks_done = 0, v_cnt = 0, p_cnt = 0, nv, np;

  always #5 mclk = ~mclk;

  dca_host_model host_u (.mclk, .ck_t, .ck_c, .cs_n, .cke, .odt, .act_n, .ras_n, .cas_n,
    .we_n, .bg, .ba, .addr, .cid, .par_in);
  dca_cmd_front dut_u (.mclk, .resetn, .dram_reset_n, .backup_armed, .ck_t, .ck_c, .cs_n,
    .cke, .odt, .act_n, .ras_n, .cas_n, .we_n, .bg, .ba, .addr, .cid, .par_in, .org, .stack,
    .die_id, .ddp_die, .parity_en, .rtt_disabled, .tdqs_en, .cmd_valid, .cmd_code, .cmd_bg,
    .cmd_ba, .cmd_addr, .mr_sel, .parity_err, .pwr_state, .clk_en, .buf_cmd_en, .buf_odt_en,
    .buf_ck_en, .open_banks, .odt_apply, .odt_mask_lines);

  always @(posedge mclk) begin
    v_cnt += int'(cmd_valid === 1'b1);
    p_cnt += int'(parity_err === 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one frame; nv and np count strobes and parity flags it caused
  task automatic cmd(input logic [1:0] cs, input logic [1:0] ke, input logic [1:0] od,
                     input logic [3:0] op, input logic [2:0] c, input logic bad);
    int v0 = v_cnt;
    int p0 = p_cnt;
    host_u.frame(cs, ke, od, op, 2'h0, 2'h0, 14'h0000, c, bad);
    #1;
    nv = v_cnt - v0;
    np = p_cnt - p0;
  endtask

  task automatic send(input logic [3:0] op, input logic [1:0] g, input logic [1:0] b,
                      input logic [13:0] a, input logic bad);
    int v0 = v_cnt;
    int p0 = p_cnt;
    host_u.frame(2'b10, 2'b11, 2'b00, op, g, b, a, 3'h0, bad);
    #1;
    nv = v_cnt - v0;
    np = p_cnt - p0;
  endtask

  task automatic t_activate();
    send(4'h5, 2'h2, 2'h1, 14'h2A5C, 1'b0);
    chk(nv, 1);
    chk(cmd_code, CMD_ACT);
    chk(cmd_addr, 17'h16A5C);
    chk({cmd_bg, cmd_ba}, 4'h9);
    chk(open_banks[9], 1);
    chk(np, 0);
    send(4'h5, 2'h2, 2'h1, 14'h2A5C, 1'b1);
    chk(np, 1);
    @(posedge mclk);
    parity_en <= 1'b0;
    send(4'h5, 2'h2, 2'h1, 14'h2A5C, 1'b1);
    chk(np, 0);
    @(posedge mclk);
    parity_en <= 1'b1;
    $display("activate and parity done");
  endtask

  task automatic t_table();
    for (int i = 0; i < 8; i++) begin
      send({1'b1, 3'(i)}, 2'h3, 2'h2, 14'h0000, 1'b0);
      chk(nv, 1);
      chk(cmd_code, i);
      chk(cmd_addr[16:14], 0);
      chk(mr_sel, 3'h6);
    end
    $display("command table done");
  endtask

  task automatic t_select();
    cmd(2'b11, 2'b11, 2'b00, 4'hD, 3'h0, 1'b1);
    chk(nv + np, 0);
    @(posedge mclk);
    stack <= STK_2H;
    die_id <= 3'h1;
    cmd(2'b10, 2'b11, 2'b00, 4'hD, 3'h0, 1'b0);
    chk(nv, 0);
    cmd(2'b10, 2'b11, 2'b00, 4'hD, 3'h1, 1'b0);
    chk(nv, 1);
    @(posedge mclk);
    stack <= STK_DDP;
    ddp_die <= 1'b1;
    cmd(2'b10, 2'b11, 2'b00, 4'hD, 3'h0, 1'b0);
    chk(nv, 0);
    cmd(2'b01, 2'b11, 2'b00, 4'hD, 3'h0, 1'b0);
    chk(nv, 1);
    @(posedge mclk);
    stack <= STK_1H;
    ddp_die <= 1'b0;
    org <= ORG_X16;
    send(4'h0, 2'h3, 2'h0, 14'h0000, 1'b0);
    chk({cmd_bg, open_banks[4]}, 3'h3);
    @(posedge mclk);
    org <= ORG_X4;
    $display("selection done");
  endtask

  task automatic t_power();
    cmd(2'b10, 2'b00, 2'b00, 4'hF, 3'h0, 1'b0);
    chk(pwr_state, PWR_APD);
    chk({clk_en, buf_cmd_en, buf_odt_en, buf_ck_en}, 4'h3);
    send(4'hF, 2'h0, 2'h0, 14'h0000, 1'b0);
    chk(pwr_state, PWR_ON);
    send(4'hA, 2'h0, 2'h0, 14'h0400, 1'b0);
    chk(open_banks, 0);
    cmd(2'b10, 2'b00, 2'b00, 4'hF, 3'h0, 1'b0);
    chk(pwr_state, PWR_PPD);
    send(4'hF, 2'h0, 2'h0, 14'h0000, 1'b0);
    cmd(2'b10, 2'b00, 2'b00, 4'h9, 3'h0, 1'b0);
    chk(pwr_state, PWR_SR);
    chk({clk_en, buf_cmd_en, buf_odt_en, buf_ck_en}, 4'h0);
    host_u.set_cke(2'b11);
    for (int k = 0; k < 20 && pwr_state !== PWR_ON; k++)
      @(posedge mclk);
    #1;
    chk(pwr_state, PWR_ON);
    if (pwr_state !== PWR_ON)
      complete_run();
    $display("power states done");
  endtask

  task automatic t_odt();
    cmd(2'b10, 2'b11, 2'b01, 4'hF, 3'h0, 1'b0);
    chk({odt_apply, odt_mask_lines}, 2'h2);
    @(posedge mclk);
    tdqs_en <= 1'b1;
    cmd(2'b10, 2'b11, 2'b01, 4'hF, 3'h0, 1'b0);
    chk(odt_mask_lines, 1);
    @(posedge mclk);
    rtt_disabled <= 1'b1;
    cmd(2'b10, 2'b11, 2'b01, 4'hF, 3'h0, 1'b0);
    chk(odt_apply, 0);
    $display("termination done");
  endtask

  task automatic t_reset_pin();
    send(4'h5, 2'h1, 2'h3, 14'h0000, 1'b0);
    @(posedge mclk);
    backup_armed <= 1'b1;
    dram_reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(open_banks[7], 1);
    @(posedge mclk);
    backup_armed <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(open_banks, 0);
    @(posedge mclk);
    dram_reset_n <= 1'b1;
    $display("reset pin done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(cmd_code, CMD_NOP);
    chk({pwr_state, clk_en, buf_cmd_en, buf_odt_en, buf_ck_en}, 8'h1F);
    $display("reset values done");
    t_activate();
    t_table();
    t_select();
    t_power();
    t_odt();
    t_reset_pin();
    complete_run();
  end
endmodule // test_dca_cmd_front

bind dca_cmd_front dca_cmd_front_props chk_u (.mclk, .resetn, .dram_reset_n, .backup_armed,
  .org, .parity_en, .rtt_disabled, .tdqs_en, .cmd_valid, .cmd_code, .cmd_bg, .cmd_ba,
  .cmd_addr, .mr_sel, .parity_err, .pwr_state, .clk_en, .buf_cmd_en, .buf_odt_en,
  .buf_ck_en, .open_banks, .odt_apply, .odt_mask_lines);
